// [hdl/qtc_pkg.sv]
// Constants, register map and field layout of the Q-channel trim and clock phase registers
package qtc_pkg;
   localparam int unsigned QTC_REG_W = 16;
   localparam int unsigned QTC_NUM_SLOTS = 4;
   localparam int unsigned QTC_IDX_W = 6;

   // Register indices; byte address on the bus is four times the index
   localparam logic [QTC_IDX_W-1:0] QTC_IDX_OFFSET = 6'h0a;
   localparam logic [QTC_IDX_W-1:0] QTC_IDX_GAIN = 6'h0b;
   localparam logic [QTC_IDX_W-1:0] QTC_IDX_FINE = 6'h0e;
   localparam logic [QTC_IDX_W-1:0] QTC_IDX_COARSE = 6'h0f;
   localparam logic [QTC_IDX_W-1:0] QTC_IDX_STATUS = 6'h10;

   typedef enum logic [1:0] {
      QTC_SLOT_OFFSET = 2'b00,
      QTC_SLOT_GAIN = 2'b01,
      QTC_SLOT_FINE = 2'b10,
      QTC_SLOT_COARSE = 2'b11
   } qtc_slot_e;

   // Power-on words, indexed by slot
   localparam logic [QTC_REG_W-1:0] QTC_RST_OFFSET = 16'h007f;
   localparam logic [QTC_REG_W-1:0] QTC_RST_GAIN = 16'h807f;
   localparam logic [QTC_REG_W-1:0] QTC_RST_FINE = 16'h00ff;
   localparam logic [QTC_REG_W-1:0] QTC_RST_COARSE = 16'h007f;
   localparam logic [QTC_NUM_SLOTS-1:0][QTC_REG_W-1:0] QTC_RST_WORDS =
      {QTC_RST_COARSE, QTC_RST_FINE, QTC_RST_GAIN, QTC_RST_OFFSET};

   // Field positions
   localparam int unsigned QTC_OFS_MAG_HI = 15;
   localparam int unsigned QTC_OFS_MAG_LO = 8;
   localparam int unsigned QTC_OFS_SIGN = 7;
   localparam int unsigned QTC_GAIN_HI = 15;
   localparam int unsigned QTC_GAIN_LO = 7;
   localparam int unsigned QTC_FINE_HI = 15;
   localparam int unsigned QTC_FINE_LO = 8;
   localparam int unsigned QTC_INV_BIT = 15;
   localparam int unsigned QTC_COARSE_HI = 14;
   localparam int unsigned QTC_COARSE_LO = 10;
   localparam int unsigned QTC_MID_HI = 9;
   localparam int unsigned QTC_MID_LO = 7;

   // Low bits that the host must fill with ones
   localparam logic [QTC_REG_W-1:0] QTC_PAD7_MASK = 16'h007f;
   localparam logic [QTC_REG_W-1:0] QTC_PAD8_MASK = 16'h00ff;

   // Status word layout
   localparam int unsigned QTC_STAT_PAD_BIT = 0;
   localparam int unsigned QTC_STAT_CNT_LO = 8;
   localparam int unsigned QTC_STAT_CNT_W = 8;

   localparam logic [1:0] QTC_SEL_LOW16 = 2'b11;
   localparam logic [8:0] QTC_GAIN_MID = 9'h100;

   // Decodes a word index: bit 2 = trim register hit, bits 1:0 = slot
   function automatic logic [2:0] qtc_decode(input logic [QTC_IDX_W-1:0] idx);
      unique case (idx)
         QTC_IDX_OFFSET: qtc_decode = {1'b1, QTC_SLOT_OFFSET};
         QTC_IDX_GAIN: qtc_decode = {1'b1, QTC_SLOT_GAIN};
         QTC_IDX_FINE: qtc_decode = {1'b1, QTC_SLOT_FINE};
         QTC_IDX_COARSE: qtc_decode = {1'b1, QTC_SLOT_COARSE};
         default: qtc_decode = 3'h0;
      endcase
   endfunction : qtc_decode
endpackage : qtc_pkg

// [hdl/qtc_wr_if.sv]
// Write port between the bus slave and the trim word store
`timescale 1ns/1ps
interface qtc_wr_if;
   logic we;
   logic [1:0] slot;
   logic [15:0] data;
   modport bus (output we, output slot, output data);
   modport store (input we, input slot, input data);
endinterface : qtc_wr_if

// [hdl/qtc_trim_store.sv]
// Storage for the four trim and phase words, each out of its own flip-flops
`timescale 1ns/1ps
module qtc_trim_store
   import qtc_pkg::*;
(
   input wire logic i_ref_clk, // 20 MHz clock
   input wire logic i_rstn, // Async reset, active low
   qtc_wr_if.store wr, // Whole-word writes
   output logic [QTC_NUM_SLOTS-1:0][QTC_REG_W-1:0] o_words // Held words
);
   logic [QTC_NUM_SLOTS-1:0][QTC_REG_W-1:0] words_reg;
   logic [QTC_NUM_SLOTS-1:0][QTC_REG_W-1:0] words_next;

   always_comb begin
      words_next = words_reg;
      if (wr.we) begin
         words_next[wr.slot] = wr.data;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         words_reg <= QTC_RST_WORDS;
      end else begin
         words_reg <= words_next;
      end
   end

   assign o_words = words_reg;
endmodule : qtc_trim_store

// [hdl/qtc_trim_regs.sv]
// Wishbone slave and controls of the Q-channel trim and sample clock phase registers
`timescale 1ns/1ps
module qtc_trim_regs
   import qtc_pkg::*;
(
   input wire logic i_ref_clk, // 20 MHz clock
   input wire logic i_rstn, // Async reset, active low
   input wire logic i_wb_cyc, // Wishbone cycle
   input wire logic i_wb_stb, // Wishbone strobe
   input wire logic i_wb_we, // Wishbone write enable
   input wire logic [7:0] i_wb_adr, // Byte address
   input wire logic [3:0] i_wb_sel, // Byte lanes
   input wire logic [31:0] i_wb_dat, // Write data
   output logic [31:0] o_wb_dat, // Read data
   output logic o_wb_ack, // Acknowledge
   output logic [7:0] o_q_offset_mag, // Offset magnitude code
   output logic o_q_offset_neg, // Offset sign, 1 = negative
   output logic [8:0] o_q_gain_code, // Full-scale gain code
   output logic [7:0] o_fine_delay, // Fine sample clock delay
   output logic o_sample_clock_invert, // Sample clock polarity invert
   output logic [4:0] o_coarse_delay, // Coarse sample clock delay
   output logic [2:0] o_mid_step_delay_field // Intermediate sample clock delay
);
   qtc_wr_if wr ();

   logic [QTC_NUM_SLOTS-1:0][QTC_REG_W-1:0] words;
   logic ack_reg;
   logic ack_next;
   logic [31:0] rdat_reg;
   logic [31:0] rdat_next;
   logic we_reg;
   logic we_next;
   logic [1:0] slot_reg;
   logic [1:0] slot_next;
   logic [QTC_REG_W-1:0] wdat_reg;
   logic [QTC_REG_W-1:0] wdat_next;
   logic [QTC_STAT_CNT_W-1:0] cnt_reg;
   logic [QTC_STAT_CNT_W-1:0] cnt_next;
   logic pad_bad_reg;
   logic pad_bad_next;
   logic req;
   logic [2:0] dec;
   logic full_write;
   logic [QTC_REG_W-1:0] pad_mask;

   // One access per cycle pair: ack drops after each answer, so a held request is not taken twice
   assign req = i_wb_cyc && i_wb_stb && !ack_reg;
   assign dec = qtc_decode(i_wb_adr[7:2]);
   // Only a write covering both low byte lanes is complete; partial writes are dropped
   assign full_write = req && i_wb_we && dec[2] && (i_wb_sel[1:0] == QTC_SEL_LOW16);
   assign pad_mask = (dec[1:0] == QTC_SLOT_FINE) ? QTC_PAD8_MASK : QTC_PAD7_MASK;

   always_comb begin
      ack_next = req;
      rdat_next = 32'h0;
      we_next = 1'b0;
      slot_next = slot_reg;
      wdat_next = wdat_reg;
      cnt_next = cnt_reg;
      pad_bad_next = pad_bad_reg;
      if (full_write) begin
         we_next = 1'b1;
         slot_next = dec[1:0];
         wdat_next = i_wb_dat[QTC_REG_W-1:0];
         cnt_next = cnt_reg + 8'h01;
         // Flags a host that left the padding bits clear
         pad_bad_next = ((i_wb_dat[QTC_REG_W-1:0] & pad_mask) != pad_mask);
      end
      if (req && !i_wb_we && (i_wb_adr[7:2] == QTC_IDX_STATUS)) begin
         rdat_next[QTC_STAT_CNT_LO +: QTC_STAT_CNT_W] = cnt_reg;
         rdat_next[QTC_STAT_PAD_BIT] = pad_bad_reg;
      end
      // Trim registers are write-only and read back as zero
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ack_reg <= 1'b0;
         rdat_reg <= 32'h0;
         we_reg <= 1'b0;
         slot_reg <= QTC_SLOT_OFFSET;
         wdat_reg <= 16'h0;
         cnt_reg <= 8'h0;
         pad_bad_reg <= 1'b0;
      end else begin
         ack_reg <= ack_next;
         rdat_reg <= rdat_next;
         we_reg <= we_next;
         slot_reg <= slot_next;
         wdat_reg <= wdat_next;
         cnt_reg <= cnt_next;
         pad_bad_reg <= pad_bad_next;
      end
   end

   assign wr.we = we_reg;
   assign wr.slot = slot_reg;
   assign wr.data = wdat_reg;

   // Store updates on the edge at which the master samples ack
   qtc_trim_store u_store (
      .i_ref_clk(i_ref_clk),
      .i_rstn(i_rstn),
      .wr(wr),
      .o_words(words)
   );

   assign o_wb_ack = ack_reg;
   assign o_wb_dat = rdat_reg;
   // Gain drives the trim straight from the held word, no recalibration step
   assign o_q_gain_code = words[QTC_SLOT_GAIN][QTC_GAIN_HI:QTC_GAIN_LO];
   assign o_q_offset_mag = words[QTC_SLOT_OFFSET][QTC_OFS_MAG_HI:QTC_OFS_MAG_LO];
   assign o_q_offset_neg = words[QTC_SLOT_OFFSET][QTC_OFS_SIGN];
   assign o_fine_delay = words[QTC_SLOT_FINE][QTC_FINE_HI:QTC_FINE_LO];
   assign o_sample_clock_invert = words[QTC_SLOT_COARSE][QTC_INV_BIT];
   assign o_coarse_delay = words[QTC_SLOT_COARSE][QTC_COARSE_HI:QTC_COARSE_LO];
   // Delay cap near 2.1 ns is an analog property; all codes pass through unchanged
   assign o_mid_step_delay_field = words[QTC_SLOT_COARSE][QTC_MID_HI:QTC_MID_LO];

   // Helper: which slots have been written since reset
   logic [QTC_NUM_SLOTS-1:0] wrote_reg;
   logic [QTC_NUM_SLOTS-1:0] wrote_next;

   always_comb begin
      wrote_next = wrote_reg;
      if (we_reg) begin
         wrote_next[slot_reg] = 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         wrote_reg <= 4'h0;
      end else begin
         wrote_reg <= wrote_next;
      end
   end

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rstn);

   sequence s_write_slot(logic [1:0] s);
      i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we && (i_wb_sel[1:0] == QTC_SEL_LOW16)
         && dec[2] && (dec[1:0] == s);
   endsequence

   sequence s_read_trim;
      i_wb_cyc && i_wb_stb && !o_wb_ack && !i_wb_we && dec[2];
   endsequence

   sequence s_taken;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence

   sequence s_write_full;
      s_taken ##0 (i_wb_we && (i_wb_sel[1:0] == QTC_SEL_LOW16) && dec[2]);
   endsequence

   chk_ofs_mag_write: assert property (
      s_write_slot(QTC_SLOT_OFFSET) |-> ##2
         o_q_offset_mag == $past(i_wb_dat[QTC_OFS_MAG_HI:QTC_OFS_MAG_LO], 2))
      else $error("offset magnitude not taken from write");

   chk_ofs_sign_write: assert property (
      s_write_slot(QTC_SLOT_OFFSET) |-> ##2 o_q_offset_neg == $past(i_wb_dat[QTC_OFS_SIGN], 2))
      else $error("offset sign not taken from write");

   chk_ofs_reset_zero: assert property (
      !wrote_reg[QTC_SLOT_OFFSET] |-> (o_q_offset_mag == 8'h00) && !o_q_offset_neg)
      else $error("offset not zero before first write");

   chk_gain_live_update: assert property (
      s_write_slot(QTC_SLOT_GAIN) |-> ##2
         o_q_gain_code == $past(i_wb_dat[QTC_GAIN_HI:QTC_GAIN_LO], 2))
      else $error("gain code not applied two cycles after request");

   chk_gain_no_recal: assert property (
      s_write_slot(QTC_SLOT_GAIN) |=> o_wb_ack ##1
         (o_q_gain_code == $past(i_wb_dat[QTC_GAIN_HI:QTC_GAIN_LO], 2)))
      else $error("gain update delayed");

   chk_gain_reset_mid: assert property (
      !wrote_reg[QTC_SLOT_GAIN] |-> o_q_gain_code == QTC_GAIN_MID)
      else $error("gain not mid-scale before first write");

   chk_fine_write: assert property (
      (we_reg && slot_reg == QTC_SLOT_FINE) |=>
         o_fine_delay == $past(wdat_reg[QTC_FINE_HI:QTC_FINE_LO]))
      else $error("fine delay not updated");

   chk_fine_reset_zero: assert property (
      !wrote_reg[QTC_SLOT_FINE] |-> o_fine_delay == 8'h00)
      else $error("fine delay not zero after reset");

   chk_invert_write: assert property (
      (we_reg && slot_reg == QTC_SLOT_COARSE) |=>
         (o_sample_clock_invert == $past(wdat_reg[QTC_INV_BIT])))
      else $error("clock invert not updated");

   chk_coarse_reset: assert property (
      !wrote_reg[QTC_SLOT_COARSE] |-> (o_coarse_delay == 5'h00) && !o_sample_clock_invert)
      else $error("coarse field or invert not zero after reset");

   chk_coarse_write: assert property (
      s_write_slot(QTC_SLOT_COARSE) |-> ##2
         o_coarse_delay == $past(i_wb_dat[QTC_COARSE_HI:QTC_COARSE_LO], 2))
      else $error("coarse delay not taken from write");

   chk_trim_read_zero: assert property (
      s_read_trim |=> o_wb_ack && (o_wb_dat == 32'h0))
      else $error("write-only register returned data");

   chk_mid_step_write: assert property (
      s_write_slot(QTC_SLOT_COARSE) |-> ##2
         o_mid_step_delay_field == $past(i_wb_dat[QTC_MID_HI:QTC_MID_LO], 2))
      else $error("intermediate delay not taken from write");

   chk_mid_step_reset: assert property (
      !wrote_reg[QTC_SLOT_COARSE] |-> o_mid_step_delay_field == 3'h0)
      else $error("intermediate delay not zero after reset");

   chk_fine_holds: assert property (
      !(we_reg && slot_reg == QTC_SLOT_FINE) |=> $stable(o_fine_delay))
      else $error("fine delay changed without a write");

   chk_partial_ignored: assert property (
      (i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we && (i_wb_sel[1:0] != QTC_SEL_LOW16))
         |=> !we_reg)
      else $error("partial write was accepted");

   chk_ack_single: assert property (
      o_wb_ack |=> !o_wb_ack)
      else $error("ack held longer than one cycle");

   chk_ack_follows_req: assert property (
      s_taken |=> o_wb_ack)
      else $error("request not acknowledged in the next cycle");

   chk_rdat_idle_zero: assert property (
      !o_wb_ack |-> o_wb_dat == 32'h0)
      else $error("read data shown without ack");

   chk_read_no_store: assert property (
      s_taken ##0 !i_wb_we |=> !we_reg)
      else $error("read disturbed a trim word");

   chk_unmapped_ignored: assert property (
      s_taken ##0 (i_wb_we && !dec[2]) |=> !we_reg)
      else $error("write to unmapped index was stored");

   chk_store_strobe_single: assert property (
      we_reg |=> !we_reg)
      else $error("store write strobe held for two cycles");

   chk_ofs_holds: assert property (
      !(we_reg && slot_reg == QTC_SLOT_OFFSET) |=>
         $stable(o_q_offset_mag) && $stable(o_q_offset_neg))
      else $error("offset changed without a write");

   chk_gain_holds: assert property (
      !(we_reg && slot_reg == QTC_SLOT_GAIN) |=> $stable(o_q_gain_code))
      else $error("gain changed without a write");

   chk_coarse_holds: assert property (
      !(we_reg && slot_reg == QTC_SLOT_COARSE) |=> $stable(o_sample_clock_invert)
         && $stable(o_coarse_delay) && $stable(o_mid_step_delay_field))
      else $error("coarse word changed without a write");

   chk_count_write: assert property (
      s_write_full |=> cnt_reg == $past(cnt_reg) + 8'h01)
      else $error("whole write not counted");

   chk_pad_flag_set: assert property (
      s_write_full ##0 ((i_wb_dat[QTC_REG_W-1:0] & pad_mask) != pad_mask) |=> pad_bad_reg)
      else $error("cleared padding bit not flagged");

   chk_pad_flag_clear: assert property (
      s_write_full ##0 ((i_wb_dat[QTC_REG_W-1:0] & pad_mask) == pad_mask) |=> !pad_bad_reg)
      else $error("padding flag not cleared by a clean write");

   chk_status_count: assert property (
      s_taken ##0 (!i_wb_we && i_wb_adr[7:2] == QTC_IDX_STATUS) |=>
         o_wb_dat[QTC_STAT_CNT_LO +: QTC_STAT_CNT_W] == $past(cnt_reg))
      else $error("status count wrong");

   chk_status_pad: assert property (
      s_taken ##0 (!i_wb_we && i_wb_adr[7:2] == QTC_IDX_STATUS) |=>
         o_wb_dat[QTC_STAT_PAD_BIT] == $past(pad_bad_reg))
      else $error("status padding flag wrong");
endmodule : qtc_trim_regs

// [dv/qtc_host_model.sv]
// Wishbone host that writes and reads the converter trim registers
`timescale 1ns/1ps
module qtc_host_model (
   input wire logic i_ref_clk, // Bus clock
   input wire logic i_wb_ack, // Slave acknowledge
   output logic o_wb_cyc, // Cycle
   output logic o_wb_stb, // Strobe
   output logic o_wb_we, // Write enable
   output logic [7:0] o_wb_adr, // Byte address
   output logic [3:0] o_wb_sel, // Byte lanes
   output logic [31:0] o_wb_dat, // Write data
   output logic o_hung // Request still outstanding
);
   initial begin
      o_wb_cyc = 1'b0;
      o_wb_stb = 1'b0;
      o_wb_we = 1'b0;
      o_wb_adr = 8'h00;
      o_wb_sel = 4'h0;
      o_wb_dat = 32'h0;
      o_hung = 1'b0;
   end
   // Callers keep the padding bits at ones, save one deliberate clear-padding write, and the gain code in its advised span, save one dropped partial gain write
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                       input logic [31:0] dat);
      @(posedge i_ref_clk);
      o_hung <= 1'b1;
      o_wb_cyc <= 1'b1;
      o_wb_stb <= 1'b1;
      o_wb_we <= we;
      o_wb_adr <= adr;
      o_wb_sel <= sel;
      o_wb_dat <= dat;
      // Only the bench watchdog ends a wait that never sees ack
      do begin
         @(posedge i_ref_clk);
      end while (i_wb_ack !== 1'b1);
      o_hung <= 1'b0;
      o_wb_cyc <= 1'b0;
      o_wb_stb <= 1'b0;
      o_wb_we <= 1'b0;
      // Released data and lane lines get an inverted pattern; the address is left at its last value
      o_wb_dat <= ~dat;
      o_wb_sel <= ~sel;
   endtask : xfer
endmodule : qtc_host_model

// [dv/tb_top.sv]
// Self-checking bench for the Q-channel trim and clock phase registers
`timescale 1ns/1ps
module tb_top;
   import qtc_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic wb_cyc, wb_stb, wb_we, wb_ack, hung;
   logic [7:0] wb_adr, off_mag, fine;
   logic [3:0] wb_sel;
   logic [31:0] wb_wdat, wb_rdat, rdv;
   logic off_neg, inv;
   logic [8:0] gain;
   logic [4:0] crs;
   logic [2:0] mid;
   logic [15:0] words [4];
   logic [67:0] notes [$];
   logic [67:0] note;
   int fails = 0;
   int compares = 0;
   int wcount = 0;
   logic pad = 1'b0;
   always #25 i_ref_clk = ~i_ref_clk;
   qtc_trim_regs DUT (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_wb_cyc(wb_cyc),
      .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(wb_sel),
      .i_wb_dat(wb_wdat), .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack), .o_q_offset_mag(off_mag),
      .o_q_offset_neg(off_neg), .o_q_gain_code(gain), .o_fine_delay(fine),
      .o_sample_clock_invert(inv), .o_coarse_delay(crs), .o_mid_step_delay_field(mid));
   qtc_host_model host (.i_ref_clk(i_ref_clk), .i_wb_ack(wb_ack), .o_wb_cyc(wb_cyc),
      .o_wb_stb(wb_stb), .o_wb_we(wb_we), .o_wb_adr(wb_adr), .o_wb_sel(wb_sel),
      .o_wb_dat(wb_wdat), .o_hung(hung));
   function automatic logic [34:0] exp_trims();
      return {words[0][15:7], words[1][15:7], words[2][15:8], words[3][15:7]};
   endfunction : exp_trims
   function automatic logic [31:0] stat_exp();
      logic [31:0] v;
      v = 32'h0;
      v[QTC_STAT_CNT_LO +: QTC_STAT_CNT_W] = 8'(wcount);
      v[QTC_STAT_PAD_BIT] = pad;
      return v;
   endfunction : stat_exp
   task automatic check(input logic [67:0] seen, input logic [67:0] expd);
      compares++;
      if (seen !== expd) begin
         fails++;
         $display("BAD t=%0t seen=%h expected=%h", $time, seen, expd);
      end
   endtask : check
   task automatic wr(input logic [7:0] adr, input logic [15:0] data, input logic [3:0] sel);
      int s;
      logic [15:0] mask;
      s = (adr == 8'h28) ? 0 : (adr == 8'h2c) ? 1 : (adr == 8'h38) ? 2 : (adr == 8'h3c) ? 3 : -1;
      mask = (s == 2) ? QTC_PAD8_MASK : QTC_PAD7_MASK;
      if (s >= 0 && sel[1:0] == 2'b11) begin
         words[s] = data;
         wcount++;
         pad = ((data & mask) != mask);
      end
      notes.push_back({1'b0, 32'h0, exp_trims()});
      host.xfer(1'b1, adr, sel, {~data, data});
   endtask : wr
   task automatic rd(input logic [7:0] adr, input logic [31:0] expd);
      notes.push_back({1'b1, expd, exp_trims()});
      host.xfer(1'b0, adr, 4'hf, 32'h0);
   endtask : rd
   task automatic check_defaults();
      words = '{16'h007f, 16'h807f, 16'h00ff, 16'h007f};
      wcount = 0;
      pad = 1'b0;
      check({wb_ack, wb_rdat, off_mag, off_neg, gain, fine, inv, crs, mid},
            {1'b0, 32'h0, 9'h000, 9'h100, 8'h00, 9'h000});
   endtask : check_defaults
   // Random words with padding ones and the gain inside its advised span
   function automatic logic [15:0] rand_word(input int s);
      case (s)
         0: return {8'($urandom), 1'($urandom), 7'h7f};
         1: return {9'($urandom_range(9'h1c0, 9'h0c0)), 7'h7f};
         2: return {8'($urandom), 8'hff};
         default: return {9'($urandom), 7'h7f};
      endcase
   endfunction : rand_word
   always @(posedge i_ref_clk) begin
      if (wb_ack === 1'b1) begin
         rdv = wb_rdat;
         #1;
         if (notes.size() == 0) begin
            check(68'h1, 68'h0);
         end else begin
            note = notes.pop_front();
            check({note[67], rdv, off_mag, off_neg, gain, fine, inv, crs,
                   mid}, note);
         end
      end
   end
   task automatic wrap_up();
      if (hung === 1'b1 || notes.size() != 0) fails++;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   initial begin
      logic [7:0] adrs [4];
      adrs = '{8'h28, 8'h2c, 8'h38, 8'h3c};
      void'($urandom(94));
      repeat (6) @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      @(posedge i_ref_clk);
      #1 check_defaults();
      for (int s = 0; s < 4; s++) rd(adrs[s], 32'h0);
      repeat (20) begin
         int s;
         s = $urandom_range(3);
         wr(adrs[s], rand_word(s), 4'hf);
      end
      // Field boundaries, then partial and unmapped writes that must change nothing
      wr(8'h28, 16'hffff, 4'hf);
      wr(8'h28, 16'h007f, 4'hf);
      wr(8'h2c, 16'h607f, 4'hf);
      wr(8'h2c, 16'he07f, 4'hf);
      wr(8'h3c, 16'hffff, 4'hf);
      wr(8'h38, 16'hffff, 4'hf);
      wr(8'h2c, 16'h3a7f, 4'h1);
      wr(8'h3c, 16'h00ff, 4'he);
      wr(8'h44, 16'h00ff, 4'hf);
      // One write leaves padding clear on purpose so the status flag gets exercised
      wr(8'h38, 16'h5a7e, 4'hf);
      rd(8'h40, stat_exp());
      wr(8'h38, 16'hffff, 4'hf);
      rd(8'h40, stat_exp());
      for (int s = 0; s < 4; s++) rd(adrs[s], 32'h0);
      rd(8'h80, 32'h0);
      @(posedge i_ref_clk);
      i_rstn <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      @(posedge i_ref_clk);
      #1 check_defaults();
      rd(8'h40, stat_exp());
      wr(8'h3c, 16'h847f, 4'hf);
      rd(8'h40, stat_exp());
      repeat (4) @(posedge i_ref_clk);
      wrap_up();
   end
   initial begin
      #400000;
      fails++;
      wrap_up();
   end
endmodule : tb_top
